// ==== verilog/ptm_pkg.sv ====
// constants, register map and carrier types for the 10-bit periodic timer
// assumes a 32-bit apb slave, one register per aligned word, 8-bit data in the low lanes
package ptm_pkg;

  // ******************************
  // register map (byte addresses)
  // ******************************
  localparam logic [7:0] OFF_CTRL0    = 8'h00;
  localparam logic [7:0] OFF_CTRL1    = 8'h04;
  localparam logic [7:0] OFF_CNT_LO   = 8'h08;
  localparam logic [7:0] OFF_CNT_HI   = 8'h0C;
  localparam logic [7:0] OFF_DUTY_LO  = 8'h10;
  localparam logic [7:0] OFF_DUTY_HI  = 8'h14;
  localparam logic [7:0] OFF_PER_LO   = 8'h18;
  localparam logic [7:0] OFF_PER_HI   = 8'h1C;
  localparam logic [7:0] OFF_FLAGS    = 8'h20;

  // ******************************
  // field positions and reset values
  // ******************************
  localparam int          BIT_PAUSE      = 7;
  localparam int          BIT_ON         = 3;
  localparam int          POS_CSEL       = 4;
  localparam int          BIT_DUTY_FLAG  = 0;
  localparam int          BIT_PER_FLAG   = 1;
  localparam logic [7:0]  RST_BYTE       = 8'h00;
  localparam logic [9:0]  RST_CMP        = 10'h000;

  // ******************************
  // mode, output-function and clock-select codes
  // ******************************
  localparam logic [1:0]  MODE_CMP       = 2'h0;
  localparam logic [1:0]  MODE_PWM       = 2'h2;
  localparam logic [1:0]  MODE_TMR       = 2'h3;
  localparam logic [1:0]  IO_INACTIVE    = 2'h0;
  localparam logic [1:0]  IO_ACTIVE      = 2'h1;
  localparam logic [1:0]  IO_PWM         = 2'h2;
  localparam logic [1:0]  IO_PULSE       = 2'h3;
  localparam logic [2:0]  CSEL_SYS4      = 3'h0;
  localparam logic [2:0]  CSEL_SYS       = 3'h1;
  localparam logic [2:0]  CSEL_H16       = 3'h2;
  localparam logic [2:0]  CSEL_H64       = 3'h3;
  localparam logic [2:0]  CSEL_PIN_RISE  = 3'h6;
  localparam logic [2:0]  CSEL_PIN_FALL  = 3'h7;
  localparam int          DIV_SYS4       = 4;
  localparam int          DIV_H16        = 16;
  localparam int          DIV_H64        = 64;
  localparam int          DIV_SUB        = 32;

  // second control byte, laid out as software sees it
  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] io;
    logic       oc;
    logic       pol;
    logic       rsv;
    logic       cclr;
  } ptm_cfg_t;

  typedef struct packed {
    logic       rise;
    logic       fall;
  } ptm_edge_t;

endpackage

// ==== verilog/ptm_pin_sync.sv ====
// two-flop synchroniser and edge detector for the external clock pin
// assumes the pin is asynchronous to pclk
`timescale 1ns/1ns
module ptm_pin_sync (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               pin_i,
  output ptm_pkg::ptm_edge_t      edge_o
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  // first flop is read only by the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= pin_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // one driver for the whole carrier: rise first, then fall
  assign edge_o = {sync_q & ~prev_q, ~sync_q & prev_q};

endmodule // ptm_pin_sync

// ==== verilog/ptm_clk_sel.sv ====
// counter clock selection as one-cycle ticks on pclk
// assumes pin edges already synchronised; internal clocks derive from pclk
`timescale 1ns/1ns
module ptm_clk_sel #(
  parameter int SUB_DIV = ptm_pkg::DIV_SUB
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic [2:0]         sel_i,
  input  ptm_pkg::ptm_edge_t      edge_i,
  output logic                    tick_o
);
  logic [5:0]  pre_q;
  logic [15:0] sub_q;
  logic        sub_tick;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= 6'h00;
    end else begin
      pre_q <= pre_q + 6'h01;
    end
  end

  // sub clock is modelled as a pclk divider, so it stays phase-locked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sub_q <= 16'h0000;
    end else if (sub_tick) begin
      sub_q <= 16'h0000;
    end else begin
      sub_q <= sub_q + 16'h0001;
    end
  end

  assign sub_tick = (sub_q == 16'(SUB_DIV - 1));

  always_comb begin
    case (sel_i)
      ptm_pkg::CSEL_SYS4:     tick_o = (pre_q[1:0] == 2'(ptm_pkg::DIV_SYS4 - 1));
      ptm_pkg::CSEL_SYS:      tick_o = 1'b1;
      ptm_pkg::CSEL_H16:      tick_o = (pre_q[3:0] == 4'(ptm_pkg::DIV_H16 - 1));
      ptm_pkg::CSEL_H64:      tick_o = (pre_q == 6'(ptm_pkg::DIV_H64 - 1));
      ptm_pkg::CSEL_PIN_RISE: tick_o = edge_i.rise;
      ptm_pkg::CSEL_PIN_FALL: tick_o = edge_i.fall;
      default:                tick_o = sub_tick;
    endcase
  end

endmodule // ptm_clk_sel

// ==== verilog/ptm_timer.sv ====
// 10-bit periodic timer: apb registers, counter, comparators, output pin
// assumes apb master on pclk; external clock pin is asynchronous
`timescale 1ns/1ns
module ptm_timer #(
  parameter int SUB_DIV = ptm_pkg::DIV_SUB
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        external_clock_pin,
  output logic             timer_output_pin_o,
  output logic             timer_output_pin_oe
);

  // ******************************
  // register state
  // ******************************
  logic                 counter_pause_bit_q;
  logic [2:0]           clock_select_field_q;
  logic                 counter_on_bit_q;
  logic                 on_prev_q;
  ptm_pkg::ptm_cfg_t    timer_control_two_q;
  logic [9:0]           duty_compare_value_q;
  logic [9:0]           period_compare_value_q;
  logic [9:0]           cnt_q;
  logic                 duty_match_flag_q;
  logic                 period_match_flag_q;
  logic                 lvl_q;

  ptm_pkg::ptm_edge_t   pin_edge;
  logic                 tick;
  logic                 wr;
  logic                 rd_setup;
  logic                 mapped;
  logic [7:0]           rd_byte;
  logic                 on_rise;
  logic                 run;
  logic [9:0]           nxt;
  logic                 a_hit;
  logic                 p_hit;
  logic                 mode_cmp;
  logic                 mode_pwm;
  logic                 mode_sp;
  logic                 clr;
  logic                 p_flag_ev;
  logic                 sp_trig;
  logic                 pin_d;
  logic                 oe_d;

  ptm_pin_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_i   (external_clock_pin),
    .edge_o  (pin_edge)
  );

  ptm_clk_sel #(.SUB_DIV(SUB_DIV)) u_clk (
    .pclk    (pclk),
    .presetn (presetn),
    .sel_i   (clock_select_field_q),
    .edge_i  (pin_edge),
    .tick_o  (tick)
  );

  // ******************************
  // apb slave: zero wait states, error on unmapped word
  // ******************************
  function automatic logic is_wr(input logic [7:0] a);
    is_wr = wr && (paddr == a);
  endfunction

  assign wr       = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready   = 1'b1;
  assign mapped   = (paddr[1:0] == 2'h0) && (paddr <= ptm_pkg::OFF_FLAGS);
  assign pslverr  = psel && penable && !mapped;

  always_comb begin
    case (paddr)
      ptm_pkg::OFF_CTRL0:   rd_byte = {counter_pause_bit_q, clock_select_field_q,
                                       counter_on_bit_q, 3'h0};
      ptm_pkg::OFF_CTRL1:   rd_byte = timer_control_two_q;
      ptm_pkg::OFF_CNT_LO:  rd_byte = cnt_q[7:0];
      ptm_pkg::OFF_CNT_HI:  rd_byte = {6'h00, cnt_q[9:8]};
      ptm_pkg::OFF_DUTY_LO: rd_byte = duty_compare_value_q[7:0];
      ptm_pkg::OFF_DUTY_HI: rd_byte = {6'h00, duty_compare_value_q[9:8]};
      ptm_pkg::OFF_PER_LO:  rd_byte = period_compare_value_q[7:0];
      ptm_pkg::OFF_PER_HI:  rd_byte = {6'h00, period_compare_value_q[9:8]};
      ptm_pkg::OFF_FLAGS:   rd_byte = {6'h00, period_match_flag_q, duty_match_flag_q};
      default:              rd_byte = ptm_pkg::RST_BYTE;
    endcase
  end

  // read data captured in the setup cycle, stable through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= {24'h00_0000, rd_byte};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_pause_bit_q  <= 1'b0;
      clock_select_field_q <= 3'h0;
      timer_control_two_q  <= ptm_pkg::RST_BYTE;
    end else begin
      if (is_wr(ptm_pkg::OFF_CTRL0)) begin
        counter_pause_bit_q  <= pwdata[ptm_pkg::BIT_PAUSE];
        clock_select_field_q <= pwdata[ptm_pkg::POS_CSEL +: 3];
      end
      if (is_wr(ptm_pkg::OFF_CTRL1)) begin
        timer_control_two_q <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_compare_value_q   <= ptm_pkg::RST_CMP;
      period_compare_value_q <= ptm_pkg::RST_CMP;
    end else begin
      if (is_wr(ptm_pkg::OFF_DUTY_LO)) duty_compare_value_q[7:0] <= pwdata[7:0];
      if (is_wr(ptm_pkg::OFF_DUTY_HI)) duty_compare_value_q[9:8] <= pwdata[1:0];
      if (is_wr(ptm_pkg::OFF_PER_LO))  period_compare_value_q[7:0] <= pwdata[7:0];
      if (is_wr(ptm_pkg::OFF_PER_HI))  period_compare_value_q[9:8] <= pwdata[1:0];
    end
  end

  // ******************************
  // mode decode and comparators
  // ******************************
  assign mode_cmp = (timer_control_two_q.mode == ptm_pkg::MODE_CMP) ||
                    (timer_control_two_q.mode == ptm_pkg::MODE_TMR);
  assign mode_pwm = (timer_control_two_q.mode == ptm_pkg::MODE_PWM) &&
                    (timer_control_two_q.io != ptm_pkg::IO_PULSE);
  assign mode_sp  = (timer_control_two_q.mode == ptm_pkg::MODE_PWM) &&
                    (timer_control_two_q.io == ptm_pkg::IO_PULSE);

  assign on_rise = counter_on_bit_q && !on_prev_q;
  assign run     = tick && counter_on_bit_q && !on_rise && !counter_pause_bit_q;
  assign nxt     = cnt_q + 10'h001;
  // a duty value of zero never matches: the count simply wraps at 3FF
  assign a_hit   = run && (duty_compare_value_q != ptm_pkg::RST_CMP) &&
                   (nxt == duty_compare_value_q);
  // period zero matches the wrap to zero, i.e. overflow
  assign p_hit   = run && (nxt == period_compare_value_q);

  always_comb begin
    clr       = 1'b0;
    p_flag_ev = 1'b0;
    if (mode_pwm) begin
      clr       = p_hit;
      p_flag_ev = p_hit;
    end else if (mode_cmp && timer_control_two_q.cclr) begin
      clr       = a_hit;
    end else if (mode_cmp) begin
      clr       = p_hit;
      p_flag_ev = p_hit;
    end
  end

  // ******************************
  // on bit and counter
  // ******************************
  assign sp_trig = mode_sp && ((clock_select_field_q == ptm_pkg::CSEL_PIN_FALL) ?
                               pin_edge.fall : pin_edge.rise);

  // pin trigger beats a same-cycle clear; a duty match beats a software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_on_bit_q <= 1'b0;
    end else if (sp_trig) begin
      counter_on_bit_q <= 1'b1;
    end else if (mode_sp && a_hit) begin
      counter_on_bit_q <= 1'b0;
    end else if (is_wr(ptm_pkg::OFF_CTRL0)) begin
      counter_on_bit_q <= pwdata[ptm_pkg::BIT_ON];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_prev_q <= 1'b0;
    end else begin
      on_prev_q <= counter_on_bit_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= ptm_pkg::RST_CMP;
    end else if (on_rise) begin
      cnt_q <= ptm_pkg::RST_CMP;
    end else if (run) begin
      cnt_q <= clr ? ptm_pkg::RST_CMP : nxt;
    end
  end

  // hardware set wins over a same-cycle write-one-to-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_match_flag_q   <= 1'b0;
      period_match_flag_q <= 1'b0;
    end else begin
      if (a_hit) begin
        duty_match_flag_q <= 1'b1;
      end else if (is_wr(ptm_pkg::OFF_FLAGS) && pwdata[ptm_pkg::BIT_DUTY_FLAG]) begin
        duty_match_flag_q <= 1'b0;
      end
      if (p_flag_ev) begin
        period_match_flag_q <= 1'b1;
      end else if (is_wr(ptm_pkg::OFF_FLAGS) && pwdata[ptm_pkg::BIT_PER_FLAG]) begin
        period_match_flag_q <= 1'b0;
      end
    end
  end

  // ******************************
  // output pin
  // ******************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_q <= 1'b0;
    end else if (on_rise) begin
      lvl_q <= timer_control_two_q.oc;
    end else if (a_hit) begin
      case (timer_control_two_q.io)
        ptm_pkg::IO_ACTIVE: lvl_q <= 1'b0;
        ptm_pkg::IO_PWM:    lvl_q <= 1'b1;
        ptm_pkg::IO_PULSE:  lvl_q <= ~lvl_q;
        default:            lvl_q <= lvl_q;
      endcase
    end
  end

  always_comb begin
    oe_d  = 1'b1;
    pin_d = 1'b0;
    case (timer_control_two_q.mode)
      ptm_pkg::MODE_CMP: pin_d = lvl_q;
      ptm_pkg::MODE_PWM: begin
        case (timer_control_two_q.io)
          ptm_pkg::IO_INACTIVE: pin_d = ~timer_control_two_q.oc;
          ptm_pkg::IO_ACTIVE:   pin_d = timer_control_two_q.oc;
          // with a nonzero period, duty at or above it keeps the count below duty all period
          ptm_pkg::IO_PWM:      pin_d = (cnt_q < duty_compare_value_q) ?
                                        timer_control_two_q.oc :
                                        ~timer_control_two_q.oc;
          default:              pin_d = counter_on_bit_q ? timer_control_two_q.oc :
                                        ~timer_control_two_q.oc;
        endcase
      end
      default:           oe_d = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_output_pin_o  <= 1'b0;
      timer_output_pin_oe <= 1'b0;
    end else begin
      timer_output_pin_o  <= oe_d & (pin_d ^ timer_control_two_q.pol);
      timer_output_pin_oe <= oe_d;
    end
  end

  // ******************************
  // assertions
  // ******************************
  a_hi_byte_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pwrite && (paddr == ptm_pkg::OFF_PER_HI)) |-> (prdata[31:2] == 30'h0))
    else $error("period high byte upper bits not zero");

  a_on_rise_zero: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(counter_on_bit_q) |=> (cnt_q == 10'h000))
    else $error("counter not zeroed on on-bit rise");

  a_pause_holds: assert property (@(posedge pclk) disable iff (!presetn)
    (counter_pause_bit_q && !on_rise) |=> $stable(cnt_q))
    else $error("counter moved while paused");

  a_duty_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
    a_hit |=> duty_match_flag_q)
    else $error("duty match did not set its flag");

  a_cclr_no_pflag: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_cmp && timer_control_two_q.cclr && !period_match_flag_q) |=> !period_match_flag_q)
    else $error("period flag set with clear-select high");

  a_pwm_full_duty: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_pwm && (timer_control_two_q.io == ptm_pkg::IO_PWM) &&
     (period_compare_value_q != 10'h000) && (cnt_q < period_compare_value_q) &&
     (duty_compare_value_q >= period_compare_value_q))
    |=> (timer_output_pin_o == ($past(timer_control_two_q.oc) ^ $past(timer_control_two_q.pol))))
    else $error("pwm not fully active with duty at or above period");

  a_sp_match_off: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_sp && a_hit && !sp_trig) |=> !counter_on_bit_q ##1 (timer_output_pin_o ==
      (~$past(timer_control_two_q.oc, 2) ^ $past(timer_control_two_q.pol, 2))))
    else $error("pulse not ended by duty match");

  a_tmr_released: assert property (@(posedge pclk) disable iff (!presetn)
    (timer_control_two_q.mode == ptm_pkg::MODE_TMR) |=> !timer_output_pin_oe)
    else $error("pin driven in timer mode");

  a_cm_init_lvl: assert property (@(posedge pclk) disable iff (!presetn)
    (on_rise && (timer_control_two_q.mode == ptm_pkg::MODE_CMP) && $stable(timer_control_two_q))
    |=> ##1 (timer_output_pin_o == ($past(timer_control_two_q.oc, 2) ^
                                    $past(timer_control_two_q.pol, 2))) or $changed(timer_control_two_q) or a_hit)
    else $error("initial level not loaded on on-bit rise");

endmodule // ptm_timer

// ==== test/ptm_pin_model.sv ====
// far-side model: drives the external clock pin, idle low between pulses
// assumes the bench requests a pulse with a one-cycle fire on pclk
`timescale 1ns/1ns
module ptm_pin_model (
  input  wire logic pclk,
  input  wire logic fire,
  output logic      pin
);
  int unsigned n;
  initial begin
    pin = 1'b0;
    n = 0;
  end
  // six cycles high so the edge survives the two-flop synchroniser
  always @(posedge pclk) begin
    if (fire)
      n <= 6;
    else if (n != 0)
      n <= n - 1;
    pin <= fire || (n > 1);
  end
endmodule // ptm_pin_model

// ==== test/ptm_timer_tb.sv ====
// self-checking bench for the 10-bit periodic timer, apb master tasks
// assumes ptm_pin_model on the external clock pin and pclk at 100 MHz
`timescale 1ns/1ns
`define CHK(a, e) begin \
  n_checks++; \
  if ((a) !== (e)) begin \
    miscompares++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); \
  end \
end
module ptm_timer_tb;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q, a, b;
  logic        pready, pslverr, pin, fire, pin_o, pin_oe, perr;
  int          miscompares;
  int          n_checks;
  int          k;
  ptm_timer #(.SUB_DIV(2)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .external_clock_pin(pin),
    .timer_output_pin_o(pin_o), .timer_output_pin_oe(pin_oe)
  );
  ptm_pin_model i_pin (.pclk(pclk), .fire(fire), .pin(pin));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // ****************
  // bus and helpers
  // ****************
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait for pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    apb(1'b1, ad, {24'h0, d}, q);
  endtask
  task automatic rd(input logic [7:0] ad, output logic [31:0] d);
    apb(1'b0, ad, 32'h0, d);
  endtask
  task automatic hi_cnt(input int n, output int h);
    h = 0;
    repeat (n) begin
      @(posedge pclk);
      #1;
      h += (pin_o === 1'b1);
    end
  endtask
  // one-cycle request to the pin model for a single pin pulse
  task automatic pulse();
    @(posedge pclk);
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
  endtask
  // mode changes only while the counter is off
  task automatic start(input logic [9:0] du, pe, input logic [7:0] c1, c0);
    wr(ptm_pkg::OFF_CTRL0, 8'h00);
    wr(ptm_pkg::OFF_DUTY_LO, du[7:0]);
    wr(ptm_pkg::OFF_DUTY_HI, {6'h0, du[9:8]});
    wr(ptm_pkg::OFF_PER_LO, pe[7:0]);
    wr(ptm_pkg::OFF_PER_HI, {6'h0, pe[9:8]});
    wr(ptm_pkg::OFF_CTRL1, c1);
    wr(ptm_pkg::OFF_FLAGS, 8'h03);
    wr(ptm_pkg::OFF_CTRL0, c0);
    repeat (8) @(posedge pclk);
    #1;
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_regs();
    for (int i = 0; i < 4; i++) begin
      logic [7:0] ad;
      ad = ptm_pkg::OFF_DUTY_LO + 8'(4 * i);
      rd(ad, q);
      `CHK(q, 32'h0)
      wr(ad, 8'hFF);
      rd(ad, q);
      `CHK(q, i[0] ? 32'h3 : 32'hFF)
    end
    rd(8'h24, q);
    `CHK({perr, q}, 33'h1_0000_0000)
  endtask
  task automatic t_pwm();
    logic [9:0] du[7] = '{2, 1, 1, 5, 1, 2, 2};
    logic [7:0] cf[7] = '{8'hA8, 8'hAC, 8'hA0, 8'hA8, 8'hA9, 8'h88, 8'h98};
    int         ex[7] = '{20, 30, 30, 40, 10, 0, 40};
    for (int i = 0; i < 7; i++) begin
      start(du[i], 10'd4, cf[i], 8'h18);
      hi_cnt(40, k);
      `CHK(k, ex[i])
    end
    wr(ptm_pkg::OFF_FLAGS, 8'h03);
    repeat (8) @(posedge pclk);
    rd(ptm_pkg::OFF_FLAGS, q);
    `CHK(q[1:0], 2'h3)
    start(10'd1000, 10'd0, 8'hA8, 8'h18);
    hi_cnt(2048, k);
    `CHK(k, 2000)
  endtask
  task automatic t_cmp();
    start(10'd3, 10'd5, 8'h30, 8'h18);
    hi_cnt(50, k);
    `CHK(k, 25)
    `CHK(pin_oe, 1'b1)
    rd(ptm_pkg::OFF_FLAGS, q);
    `CHK(q[1:0], 2'h3)
    start(10'd20, 10'd30, 8'h18, 8'h18);
    `CHK(pin_o, 1'b1)
    repeat (30) @(posedge pclk);
    #1;
    `CHK(pin_o, 1'b0)
    wr(ptm_pkg::OFF_CTRL0, 8'h00);
    wr(ptm_pkg::OFF_CTRL0, 8'h18);
    repeat (3) @(posedge pclk);
    #1;
    `CHK(pin_o, 1'b1)
    start(10'd4, 10'd2, 8'h31, 8'h18);
    rd(ptm_pkg::OFF_FLAGS, q);
    `CHK(q[1:0], 2'h1)
    start(10'd0, 10'd5, 8'h30, 8'h18);
    rd(ptm_pkg::OFF_FLAGS, q);
    `CHK(q[1:0], 2'h2)
    start(10'd3, 10'd5, 8'hF0, 8'h18);
    `CHK(pin_oe, 1'b0)
    rd(ptm_pkg::OFF_FLAGS, q);
    `CHK(q[1:0], 2'h3)
  endtask
  task automatic t_cnt();
    start(10'd0, 10'd0, 8'h30, 8'h18);
    wr(ptm_pkg::OFF_CTRL0, 8'h98);
    rd(ptm_pkg::OFF_CNT_LO, a);
    repeat (5) @(posedge pclk);
    rd(ptm_pkg::OFF_CNT_LO, b);
    `CHK(b, a)
    wr(ptm_pkg::OFF_CTRL0, 8'h18);
    rd(ptm_pkg::OFF_CNT_LO, a);
    `CHK(8'(a - b) > 0 && 8'(a - b) < 20, 1'b1)
    wr(ptm_pkg::OFF_CTRL0, 8'h10);
    rd(ptm_pkg::OFF_CNT_LO, a);
    repeat (5) @(posedge pclk);
    rd(ptm_pkg::OFF_CNT_LO, b);
    `CHK(b, a)
    wr(ptm_pkg::OFF_CTRL0, 8'h18);
    rd(ptm_pkg::OFF_CNT_LO, a);
    `CHK(a[7:0] < 8, 1'b1)
  endtask
  // counts over a 67-cycle gap between two counter samples
  task automatic t_clk();
    int dv[6] = '{4, 1, 16, 64, 2, 2};
    int d;
    for (int i = 0; i < 6; i++) begin
      start(10'd0, 10'd0, 8'h30, {1'b0, 3'(i), 4'h8});
      rd(ptm_pkg::OFF_CNT_LO, a);
      repeat (64) @(posedge pclk);
      rd(ptm_pkg::OFF_CNT_LO, b);
      d = int'(8'(b - a));
      `CHK(d + 2 >= 67 / dv[i] && d <= 67 / dv[i] + 2, 1'b1)
    end
    // pin rising then falling edge as counter clock: one count per pin pulse
    for (int i = 6; i < 8; i++) begin
      start(10'd0, 10'd0, 8'h30, {1'b0, 3'(i), 4'h8});
      rd(ptm_pkg::OFF_CNT_LO, a);
      repeat (3) begin
        pulse();
        repeat (10) @(posedge pclk);
      end
      rd(ptm_pkg::OFF_CNT_LO, b);
      `CHK(8'(b - a), 8'h03)
    end
  endtask
  task automatic t_pulse();
    // counter on pclk, off until the rising pin edge starts it
    start(10'd8, 10'd0, 8'hB8, 8'h10);
    pulse();
    hi_cnt(40, k);
    `CHK(k >= 7 && k <= 9, 1'b1)
    rd(ptm_pkg::OFF_CTRL0, q);
    `CHK(q[7:0], 8'h10)
    rd(ptm_pkg::OFF_FLAGS, q);
    `CHK(q[0], 1'b1)
    wr(ptm_pkg::OFF_CTRL0, 8'h18);
    hi_cnt(40, k);
    `CHK(k >= 7 && k <= 9, 1'b1)
  endtask
  task automatic report_and_stop();
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fire = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_pwm();
    t_cmp();
    t_cnt();
    t_clk();
    t_pulse();
    report_and_stop();
  end
  // the whole run needs about 3900 cycles
  initial begin
    #500000;
    miscompares++;
    report_and_stop();
  end
endmodule // ptm_timer_tb
